/* File: power_pkg.sv */
// shared constants and types for the coordinator
package power_pkg;

  // idle-state codes; the numeric order gives the depth order C1 < C3 < C6
  typedef enum logic [2:0] {
    CST_C0  = 3'h0,
    CST_C1  = 3'h1,
    CST_C1E = 3'h2,
    CST_C3  = 3'h3,
    CST_C6  = 3'h6
  } cstate_type;

  // per-core idle sequencing, gray along all three entries
  typedef enum logic [2:0] {
    CORE_ACTIVE = 3'h0,
    CORE_FLUSH  = 3'h1,
    CORE_GATED  = 3'h3,
    CORE_SAVE   = 3'h4,
    CORE_OFF    = 3'h5,
    CORE_HALT   = 3'h2
  } core_state_type;

  // pstate sequencer, gray along both paths out of idle, not on the return to idle
  typedef enum logic [2:0] {
    SEQ_IDLE      = 3'h0,
    SEQ_UP_RAMP   = 3'h1,
    SEQ_UP_RELOCK = 3'h3,
    SEQ_DN_RELOCK = 3'h4,
    SEQ_DN_RAMP   = 3'h6
  } seq_state_type;

  localparam int CLK_MHZ           = 100;
  localparam int RAMP_STEP_NS      = 1000;
  localparam int RAMP_STEP_CYCLES  = (RAMP_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int PLL_SETTLE_NS     = 200;
  localparam int PLL_SETTLE_CYCLES = (PLL_SETTLE_NS * CLK_MHZ + 999) / 1000;

  localparam logic [3:0] PSTATE_MIN     = 4'h0;
  localparam logic [3:0] PSTATE_RESET   = 4'h0;
  localparam logic [7:0] VID_BASE       = 8'h20;
  localparam logic [7:0] VID_PER_PSTATE = 8'h04;
  localparam logic [7:0] VID_PER_CORE   = 8'h01;
  localparam logic [7:0] VID_RESET      = 8'h20;

endpackage : power_pkg

/* File: idle_if.sv */
// carrier between the coordinator and one core's idle resolver
interface idle_if;
  logic                  req_valid;
  logic                  req_thread;
  power_pkg::cstate_type req_state;
  logic [1:0]            wake;
  logic                  smt_en;
  logic                  flush_done;
  logic                  save_done;
  power_pkg::cstate_type resolved;
  logic                  in_c0;
  logic                  clk_gate;
  logic                  flush_req;
  logic                  save_req;
  logic                  power_off;

  modport ctrl (output req_valid, req_thread, req_state, wake, smt_en, flush_done, save_done,
                input  resolved, in_c0, clk_gate, flush_req, save_req, power_off);
  modport core (input  req_valid, req_thread, req_state, wake, smt_en, flush_done, save_done,
                output resolved, in_c0, clk_gate, flush_req, save_req, power_off);
endinterface : idle_if

/* File: core_idle_resolver.sv */
// per-core thread idle tracking, core resolution and entry/exit sequencing
module core_idle_resolver (
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  idle_if.core      port_if
);

  power_pkg::cstate_type     thread_state [2];
  power_pkg::cstate_type     thread_pend  [2];
  logic [1:0]                pend_valid;
  power_pkg::cstate_type     target;
  power_pkg::core_state_type core_st;

  // per-thread request tracking; without smt one request drives both threads
  for (genvar t = 0; t < 2; t++) begin : g_thread
    logic hit;
    logic woken;
    assign hit   = port_if.req_valid && (!port_if.smt_en || port_if.req_thread == t[0]); // R7
    assign woken = port_if.smt_en ? port_if.wake[t] : |port_if.wake;
    always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
        thread_state[t] <= power_pkg::CST_C0;                                 // R17
        thread_pend[t]  <= power_pkg::CST_C0;
        pend_valid[t]   <= 1'b0;
      end else if (woken) begin
        thread_state[t] <= power_pkg::CST_C0;                                 // R15
        pend_valid[t]   <= 1'b0;
      end else if (hit && thread_state[t] != power_pkg::CST_C0 && port_if.req_state != power_pkg::CST_C0) begin
        // deeper-to-deeper change is parked one cycle in C0
        thread_state[t] <= power_pkg::CST_C0;                                 // R9
        thread_pend[t]  <= port_if.req_state;
        pend_valid[t]   <= 1'b1;
      end else if (hit) begin
        thread_state[t] <= port_if.req_state;
        pend_valid[t]   <= 1'b0;
      end else if (pend_valid[t]) begin
        thread_state[t] <= thread_pend[t];
        pend_valid[t]   <= 1'b0;
      end
    end
  end

  // core target: c0 if any thread runs, else the shallower thread state
  always_comb begin
    if (thread_state[0] == power_pkg::CST_C0 || thread_state[1] == power_pkg::CST_C0) begin
      target = power_pkg::CST_C0;                                             // R10
    end else if (thread_state[0] < thread_state[1]) begin
      target = thread_state[0];                                               // R10
    end else begin
      target = thread_state[1];
    end
  end

  // power actions follow the resolved target, via active
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      core_st <= power_pkg::CORE_ACTIVE;                                      // R16
    end else begin
      unique case (core_st)
        power_pkg::CORE_ACTIVE: begin
          if (target == power_pkg::CST_C1) begin
            core_st <= power_pkg::CORE_HALT;                                  // R8
          end else if (target == power_pkg::CST_C3) begin
            core_st <= power_pkg::CORE_FLUSH;                                 // R13
          end else if (target == power_pkg::CST_C6) begin
            core_st <= power_pkg::CORE_SAVE;                                  // R14
          end
        end
        power_pkg::CORE_HALT: begin
          if (target != power_pkg::CST_C1) core_st <= power_pkg::CORE_ACTIVE; // R9
        end
        power_pkg::CORE_FLUSH: begin
          if (target != power_pkg::CST_C3) begin
            core_st <= power_pkg::CORE_ACTIVE;                                // R9
          end else if (port_if.flush_done) begin
            core_st <= power_pkg::CORE_GATED;                                 // R13
          end
        end
        power_pkg::CORE_GATED: begin
          if (target != power_pkg::CST_C3) core_st <= power_pkg::CORE_ACTIVE;
        end
        power_pkg::CORE_SAVE: begin
          if (target != power_pkg::CST_C6) begin
            core_st <= power_pkg::CORE_ACTIVE;
          end else if (port_if.save_done) begin
            core_st <= power_pkg::CORE_OFF;                                   // R14
          end
        end
        power_pkg::CORE_OFF: begin
          if (target != power_pkg::CST_C6) core_st <= power_pkg::CORE_ACTIVE;
        end
        default: core_st <= power_pkg::CORE_ACTIVE;
      endcase
    end
  end

  // state reported only once the entry has completed
  always_comb begin
    unique case (core_st)
      power_pkg::CORE_HALT:  port_if.resolved = power_pkg::CST_C1;
      power_pkg::CORE_GATED: port_if.resolved = power_pkg::CST_C3;
      power_pkg::CORE_OFF:   port_if.resolved = power_pkg::CST_C6;
      default:               port_if.resolved = power_pkg::CST_C0;
    endcase
  end

  assign port_if.in_c0     = (core_st == power_pkg::CORE_ACTIVE);
  assign port_if.clk_gate  = (core_st == power_pkg::CORE_GATED) || (core_st == power_pkg::CORE_OFF);
  assign port_if.flush_req = (core_st == power_pkg::CORE_FLUSH);
  assign port_if.save_req  = (core_st == power_pkg::CORE_SAVE);
  assign port_if.power_off = (core_st == power_pkg::CORE_OFF);

endmodule : core_idle_resolver

/* File: core_power_state_coordinator.sv */
// top: per-core idle coordination and performance-state voltage/pll sequencing
// Operation
// R1 - software pstate request; voltage from frequency, cores
// R2 - rising: step voltage up, then relock pll
// R3 - falling: relock pll first, then lower voltage
// R4 - shared point follows highest active core request
// R5 - requests during transition wait until it ends
// R6 - voltage moves one step per ramp interval
// R7 - per-thread requests only with multithreading enabled
// R8 - power actions only from resolved core state
// R9 - idle changes always pass through c0
// R10 - core c0 if any thread c0, else shallower
// R11 - all enabled cores idle with option: c1e
// R12 - c1e runs lowest frequency and voltage point
// R13 - c3 entry: flush caches, then gate clocks
// R14 - c6 entry: save state, then remove voltage
// R15 - interrupt wakes only the addressed thread; without multithreading any wake bit wakes both threads
// R16 - system reset reinitializes all cores
// R17 - after reset all c0, nothing pending
// R18 - busy from voltage stepping to final lock
module core_power_state_coordinator #(
  parameter int NUM_CORES = 2,
  parameter int PST_W     = 4,
  parameter int VID_W     = 8
) (
  input  wire logic                         mclk_i,
  input  wire logic                         sys_rst_i,
  input  wire logic                         smt_enable_i,
  input  wire logic                         c1e_enable_i,
  input  wire logic [NUM_CORES-1:0]         core_enable_i,
  input  wire logic [NUM_CORES-1:0]         thread_req_valid_i,
  input  wire logic [NUM_CORES-1:0]         thread_req_thread_i,
  input  wire logic [NUM_CORES-1:0][2:0]    thread_req_state_i,
  input  wire logic [NUM_CORES-1:0][1:0]    thread_wake_i,
  input  wire logic [NUM_CORES-1:0]         flush_done_i,
  input  wire logic [NUM_CORES-1:0]         save_done_i,
  input  wire logic [NUM_CORES-1:0]         pstate_wr_i,
  input  wire logic [PST_W-1:0]             pstate_data_i,
  input  wire logic                         pll_lock_i,
  input  wire logic                         vr_good_i,
  output logic      [NUM_CORES-1:0][2:0]    core_cstate_o,
  output logic      [NUM_CORES-1:0]         core_clk_gate_o,
  output logic      [NUM_CORES-1:0]         core_flush_req_o,
  output logic      [NUM_CORES-1:0]         core_save_req_o,
  output logic      [NUM_CORES-1:0]         core_power_off_o,
  output logic                              vid_cmd_valid_o,
  output logic      [VID_W-1:0]             vid_code_o,
  output logic      [PST_W-1:0]             pll_ratio_o,
  output logic                              pll_relock_o,
  output logic                              pstate_busy_o
);

  localparam int CNT_W = $clog2(NUM_CORES + 1);
  localparam int TMR_W = $clog2(power_pkg::RAMP_STEP_CYCLES + power_pkg::PLL_SETTLE_CYCLES + 1);

  logic [NUM_CORES-1:0][PST_W-1:0] pstate_req;
  logic [NUM_CORES-1:0]            core_in_c0;
  logic [NUM_CORES-1:0]            core_idle;
  power_pkg::cstate_type           core_res [NUM_CORES];
  logic [1:0]                      lock_sync;
  logic [1:0]                      good_sync;
  logic                            lock_s;
  logic                            good_s;
  logic [PST_W-1:0]                max_pst;
  logic [CNT_W-1:0]                active_cnt;
  logic                            c1e_now;
  logic [PST_W-1:0]                goal_pst;
  logic [VID_W-1:0]                goal_vid;
  power_pkg::seq_state_type        seq_st;
  logic [PST_W-1:0]                cur_pst;
  logic [PST_W-1:0]                tgt_pst;
  logic [VID_W-1:0]                tgt_vid;
  logic [TMR_W-1:0]                ramp_cnt;
  logic                            ramp_tick;
  logic [TMR_W-1:0]                settle_cnt;
  logic                            relock_done;

  // one resolver per core, joined through the carrier interface
  for (genvar c = 0; c < NUM_CORES; c++) begin : g_core
    idle_if link_if ();
    assign link_if.req_valid  = thread_req_valid_i[c];
    assign link_if.req_thread = thread_req_thread_i[c];
    assign link_if.req_state  = power_pkg::cstate_type'(thread_req_state_i[c]);
    assign link_if.wake       = thread_wake_i[c];
    assign link_if.smt_en     = smt_enable_i;
    assign link_if.flush_done = flush_done_i[c];
    assign link_if.save_done  = save_done_i[c];
    assign core_res[c]        = link_if.resolved;
    assign core_in_c0[c]      = link_if.in_c0;
    assign core_idle[c]       = (link_if.resolved != power_pkg::CST_C0);

    core_idle_resolver u_resolver (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .port_if   (link_if.core)
    );

    // registered per-core outputs; c1 shown as c1e while c1e_now holds
    always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
        core_cstate_o[c]    <= 3'h0;                                          // R17
        core_clk_gate_o[c]  <= 1'b0;
        core_flush_req_o[c] <= 1'b0;
        core_save_req_o[c]  <= 1'b0;
        core_power_off_o[c] <= 1'b0;
      end else begin
        core_cstate_o[c]    <= (c1e_now && core_res[c] == power_pkg::CST_C1) ? power_pkg::CST_C1E
                                                                              : core_res[c]; // R11
        core_clk_gate_o[c]  <= link_if.clk_gate;                              // R13
        core_flush_req_o[c] <= link_if.flush_req;
        core_save_req_o[c]  <= link_if.save_req;
        core_power_off_o[c] <= link_if.power_off;                             // R14
      end
    end

    // software-written performance request per core
    always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
        pstate_req[c] <= PST_W'(power_pkg::PSTATE_RESET);
      end else if (pstate_wr_i[c]) begin
        pstate_req[c] <= pstate_data_i;                                       // R1
      end
    end
  end

  // pll lock and regulator good: two-flop synchronisers
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      lock_sync <= 2'h0;
      good_sync <= 2'h0;
    end else begin
      lock_sync <= {lock_sync[0], pll_lock_i};
      good_sync <= {good_sync[0], vr_good_i};
    end
  end
  assign lock_s = lock_sync[1];
  assign good_s = good_sync[1];

  // shared operating point: highest request among running cores
  always_comb begin
    max_pst    = PST_W'(power_pkg::PSTATE_MIN);
    active_cnt = '0;
    for (int i = 0; i < NUM_CORES; i++) begin
      if (core_enable_i[i] && core_in_c0[i]) begin
        active_cnt = active_cnt + CNT_W'(1);
        if (pstate_req[i] > max_pst) max_pst = pstate_req[i];                 // R4
      end
    end
  end

  // c1e when every enabled core has resolved c1 or deeper
  always_comb begin
    c1e_now = c1e_enable_i && (|core_enable_i);
    for (int i = 0; i < NUM_CORES; i++) begin
      if (core_enable_i[i] && !core_idle[i]) c1e_now = 1'b0;                  // R11
    end
  end

  // voltage chosen from frequency and number of running cores
  assign goal_pst = c1e_now ? PST_W'(power_pkg::PSTATE_MIN) : max_pst;        // R12
  assign goal_vid = VID_W'(power_pkg::VID_BASE)
                  + VID_W'(goal_pst) * VID_W'(power_pkg::VID_PER_PSTATE)
                  + VID_W'(active_cnt) * VID_W'(power_pkg::VID_PER_CORE);      // R1

  // ramp divider: one voltage step per interval keeps the rail glitch-free
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || seq_st == power_pkg::SEQ_IDLE) begin
      ramp_cnt <= '0;
    end else if (ramp_cnt == TMR_W'(power_pkg::RAMP_STEP_CYCLES - 1)) begin
      ramp_cnt <= '0;                                                         // R6
    end else begin
      ramp_cnt <= ramp_cnt + TMR_W'(1);
    end
  end
  assign ramp_tick = (ramp_cnt == TMR_W'(power_pkg::RAMP_STEP_CYCLES - 1));

  // settle timer: lock is trusted only after the pll had time to drop it
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      settle_cnt <= '0;
    end else if (pll_relock_o) begin
      settle_cnt <= TMR_W'(power_pkg::PLL_SETTLE_CYCLES);
    end else if (settle_cnt != '0) begin
      settle_cnt <= settle_cnt - TMR_W'(1);
    end
  end
  assign relock_done = (settle_cnt == '0) && lock_s && !pll_relock_o;

  // sequencer; the goal is sampled only when idle, so later requests wait
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      seq_st          <= power_pkg::SEQ_IDLE;                                 // R17
      cur_pst         <= PST_W'(power_pkg::PSTATE_RESET);
      tgt_pst         <= PST_W'(power_pkg::PSTATE_RESET);
      tgt_vid         <= VID_W'(power_pkg::VID_RESET);
      vid_code_o      <= VID_W'(power_pkg::VID_RESET);
      vid_cmd_valid_o <= 1'b0;
      pll_ratio_o     <= PST_W'(power_pkg::PSTATE_RESET);
      pll_relock_o    <= 1'b0;
    end else begin
      vid_cmd_valid_o <= 1'b0;
      pll_relock_o    <= 1'b0;
      unique case (seq_st)
        power_pkg::SEQ_IDLE: begin
          tgt_pst <= goal_pst;                                                // R5
          tgt_vid <= goal_vid;
          if (goal_pst < cur_pst) begin
            pll_ratio_o  <= goal_pst;                                         // R3
            pll_relock_o <= 1'b1;
            seq_st       <= power_pkg::SEQ_DN_RELOCK;
          end else if (goal_pst != cur_pst || goal_vid != vid_code_o) begin
            seq_st <= power_pkg::SEQ_UP_RAMP;                                 // R2
          end
        end
        power_pkg::SEQ_UP_RAMP: begin
          if (ramp_tick && vid_code_o != tgt_vid) begin
            vid_code_o      <= (vid_code_o < tgt_vid) ? vid_code_o + VID_W'(1)
                                                      : vid_code_o - VID_W'(1); // R6
            vid_cmd_valid_o <= 1'b1;                                          // R2
          end else if (vid_code_o == tgt_vid && good_s && ramp_tick) begin
            // a full interval lets a stale good flag clear through the synchroniser
            if (tgt_pst != cur_pst) begin
              pll_ratio_o  <= tgt_pst;                                        // R2
              pll_relock_o <= 1'b1;
              seq_st       <= power_pkg::SEQ_UP_RELOCK;
            end else begin
              seq_st <= power_pkg::SEQ_IDLE;
            end
          end
        end
        power_pkg::SEQ_UP_RELOCK: begin
          if (relock_done) begin
            cur_pst <= tgt_pst;                                               // R18
            seq_st  <= power_pkg::SEQ_IDLE;
          end
        end
        power_pkg::SEQ_DN_RELOCK: begin
          if (relock_done) begin
            cur_pst <= tgt_pst;                                               // R3
            seq_st  <= power_pkg::SEQ_DN_RAMP;
          end
        end
        power_pkg::SEQ_DN_RAMP: begin
          if (vid_code_o == tgt_vid) begin
            seq_st <= power_pkg::SEQ_IDLE;
          end else if (ramp_tick) begin
            vid_code_o      <= (vid_code_o < tgt_vid) ? vid_code_o + VID_W'(1)
                                                      : vid_code_o - VID_W'(1); // R6
            vid_cmd_valid_o <= 1'b1;                                          // R3
          end
        end
        default: seq_st <= power_pkg::SEQ_IDLE;
      endcase
    end
  end

  // busy while the sequencer works
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pstate_busy_o <= 1'b0;
    end else begin
      pstate_busy_o <= (seq_st != power_pkg::SEQ_IDLE);                       // R18
    end
  end

endmodule : core_power_state_coordinator

/* File: vreg_model.sv */
// far-side model: regulator good flag and pll lock
module vreg_model (
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  input  wire logic slow_i,
  input  wire logic step_i,
  input  wire logic relock_i,
  output logic      vr_good_o,
  output logic      pll_lock_o
);
  int vr_cnt = 0;
  int lk_cnt = 0;

  // a step drops good, a relock drops lock; slow mode stretches both
  always_ff @(posedge mclk_i) begin
    vr_cnt <= sys_rst_i ? 0 : step_i ? (slow_i ? 30 : 2) : vr_cnt - int'(vr_cnt > 0);
    lk_cnt <= sys_rst_i ? 0 : relock_i ? (slow_i ? 30 : 3) : lk_cnt - int'(lk_cnt > 0);
  end
  assign vr_good_o  = (vr_cnt == 0);
  assign pll_lock_o = (lk_cnt == 0);
endmodule : vreg_model

/* File: core_power_state_coordinator_asserts.sv */
// port-level checker for the coordinator
module core_power_state_coordinator_asserts #(parameter int NUM_CORES = 2, parameter int PST_W = 4,
                                              parameter int VID_W = 8) (
  input  wire logic                      mclk_i,
  input  wire logic                      sys_rst_i,
  input  wire logic [NUM_CORES-1:0]      flush_done_i,
  input  wire logic [NUM_CORES-1:0]      save_done_i,
  input  wire logic [NUM_CORES-1:0][2:0] core_cstate_o,
  input  wire logic [NUM_CORES-1:0]      core_flush_req_o,
  input  wire logic [NUM_CORES-1:0]      core_save_req_o,
  input  wire logic [NUM_CORES-1:0]      core_power_off_o,
  input  wire logic                      vid_cmd_valid_o,
  input  wire logic [VID_W-1:0]          vid_code_o,
  input  wire logic [PST_W-1:0]          pll_ratio_o,
  input  wire logic                      pll_relock_o,
  input  wire logic                      pstate_busy_o
);
  int   gap;
  logic step_seen;
  logic dn_seen;
  logic flushed;
  logic saved;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  // step spacing and down steps, cleared when idle
  always_ff @(posedge mclk_i) gap <= (vid_cmd_valid_o || sys_rst_i || !pstate_busy_o) ? 0 : gap + 1;
  always_ff @(posedge mclk_i) step_seen <= !sys_rst_i && pstate_busy_o && (step_seen || vid_cmd_valid_o);
  always_ff @(posedge mclk_i) dn_seen <= !sys_rst_i && pstate_busy_o &&
                                         (dn_seen || (vid_cmd_valid_o && vid_code_o < $past(vid_code_o)));
  // core 0 flush/save done, rearmed per request
  always_ff @(posedge mclk_i) flushed <= (sys_rst_i || $rose(core_flush_req_o[0])) ? 1'b0 :
                                         flushed | (flush_done_i[0] & core_flush_req_o[0]);
  always_ff @(posedge mclk_i) saved <= (sys_rst_i || $rose(core_save_req_o[0])) ? 1'b0 :
                                       saved | (save_done_i[0] & core_save_req_o[0]);

  sequence s_busy_ends;
    ##[1:90] !pstate_busy_o;
  endsequence

  chk_reset_clears: assert property (disable iff (1'b0) sys_rst_i |=> vid_code_o == 8'h20 &&
    core_cstate_o == '0 && !pstate_busy_o && !vid_cmd_valid_o) else $error("reset state wrong");
  chk_step_busy: assert property (vid_cmd_valid_o |-> pstate_busy_o)
    else $error("step while idle");
  chk_code_on_step: assert property (!$stable(vid_code_o) |-> vid_cmd_valid_o)
    else $error("code moved unasked");
  chk_step_size: assert property (vid_cmd_valid_o |-> vid_code_o - $past(vid_code_o) inside {8'h01, 8'hFF})
    else $error("step over one code");
  chk_step_spacing: assert property (vid_cmd_valid_o && step_seen |-> gap >= power_pkg::RAMP_STEP_CYCLES - 1)
    else $error("steps too close");
  chk_up_volt_first: assert property (pll_relock_o && pll_ratio_o > $past(pll_ratio_o) |->
    !vid_cmd_valid_o throughout s_busy_ends) else $error("step after up relock");
  chk_down_relock_first: assert property (pll_relock_o && pll_ratio_o < $past(pll_ratio_o) |->
    !dn_seen || !pstate_busy_o) else $error("down step before relock");
  chk_idle_via_c0: assert property ($changed(core_cstate_o[0]) |-> core_cstate_o[0] == 3'h0 ||
    $past(core_cstate_o[0]) == 3'h0 || core_cstate_o[0] + $past(core_cstate_o[0]) == 3'h3)
    else $error("idle change skipped c0");
  chk_c3_flushed: assert property (core_cstate_o[0] == 3'h3 |-> flushed)
    else $error("c3 before flush");
  chk_off_saved: assert property (core_power_off_o[0] |-> saved)
    else $error("off before save");
endmodule : core_power_state_coordinator_asserts

bind core_power_state_coordinator core_power_state_coordinator_asserts #(.NUM_CORES(NUM_CORES), .PST_W(PST_W),
  .VID_W(VID_W)) i_chk (.*);

/* File: core_power_state_coordinator_tb_top.sv */
// self-checking bench for the core power-state coordinator
module core_power_state_coordinator_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
  logic            mclk_i = 1'b0, sys_rst_i = 1'b1, smt_enable_i = 1'b1, c1e_enable_i = 1'b0, slow = 1'b0;
  logic            pll_lock_i, vr_good_i, vid_cmd_valid_o, pll_relock_o, pstate_busy_o;
  logic [1:0]      core_enable_i = 2'h3, thread_req_valid_i = '0, thread_req_thread_i = '0, pstate_wr_i = '0;
  logic [1:0]      flush_done_i = '0, save_done_i = '0, core_clk_gate_o, core_flush_req_o, core_save_req_o;
  logic [1:0]      core_power_off_o;
  logic [1:0][2:0] thread_req_state_i = '0, core_cstate_o;
  logic [1:0][1:0] thread_wake_i = '0;
  logic [3:0]      pstate_data_i = '0, pll_ratio_o, cur = '0, er, p[2] = '{4'h0, 4'h0};
  logic [7:0]      vid_code_o;
  logic [2:0]      prev_cst = '0, ec;
  logic [3:0]      q_ratio[$];
  logic [2:0]      q_cst[$];
  logic [31:0]     lf = 32'h1C848AB7;
  int              n_fail = 0, cmp_count = 0;

  core_power_state_coordinator i_dut (.*);
  vreg_model i_vr (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .slow_i(slow), .step_i(vid_cmd_valid_o),
                   .relock_i(pll_relock_o), .vr_good_o(vr_good_i), .pll_lock_o(pll_lock_i));

  initial forever #5 mclk_i = ~mclk_i;
  // flush and save engines answer a cycle later
  always @(negedge mclk_i) begin
    flush_done_i <= core_flush_req_o;
    save_done_i  <= core_save_req_o;
  end
  // watcher: relocks and core 0 changes retire notes
  always @(negedge mclk_i) begin
    if (!sys_rst_i && pll_relock_o === 1'b1) begin
      er = q_ratio.size() ? q_ratio.pop_front() : 4'hF;
      `CHK("pll_ratio", er, pll_ratio_o)
    end
    if (!sys_rst_i && core_cstate_o[0] !== prev_cst) begin
      ec = q_cst.size() ? q_cst.pop_front() : 3'h7;
      `CHK("core_cstate", ec, core_cstate_o[0])
    end
    prev_cst = core_cstate_o[0];
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
  endfunction : lfsr
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // quiet: sequencer idle and every note retired
  task automatic wait_quiet();
    int q = 0;
    for (int k = 0; k < 20000 && q < 4; k++) begin
      @(negedge mclk_i);
      q = (pstate_busy_o === 1'b0 && q_ratio.size() + q_cst.size() == 0) ? q + 1 : 0;
    end
    if (q < 4) begin
      n_fail++;
      tally_and_finish();
    end
  endtask : wait_quiet
  task automatic wr_p(input logic [1:0] m, input logic [3:0] d);
    logic [3:0] g;
    @(negedge mclk_i);
    pstate_wr_i   = m;
    pstate_data_i = d;
    foreach (p[k]) if (m[k]) p[k] = d;
    g = (p[0] > p[1]) ? p[0] : p[1];
    if (g != cur) q_ratio.push_back(g);
    cur = g;
    @(negedge mclk_i);
    pstate_wr_i = '0;
  endtask : wr_p
  task automatic idle_req(input int c, input logic t, input logic [2:0] st);
    @(negedge mclk_i);
    thread_req_valid_i[c]  = 1'b1;
    thread_req_thread_i[c] = t;
    thread_req_state_i[c]  = st;
    @(negedge mclk_i);
    thread_req_valid_i[c] = 1'b0;
  endtask : idle_req
  task automatic wake(input int c, input logic [1:0] w);
    @(negedge mclk_i);
    thread_wake_i[c] = w;
    @(negedge mclk_i);
    thread_wake_i[c] = 2'h0;
  endtask : wake

  initial begin
    repeat (8) @(negedge mclk_i);
    `CHK("reset_outs", {6'h0, 8'h20, 4'h0, 1'b0}, {core_cstate_o, vid_code_o, pll_ratio_o, pstate_busy_o})
    sys_rst_i = 1'b0;
    wait_quiet();
    `CHK("vid_code", 8'h22, vid_code_o)
    // random write pairs, the second mid-transition
    for (int i = 0; i < 6; i++) begin
      lf   = lfsr(lf);
      slow = lf[7];
      wr_p(2'h1 << lf[0], {1'b0, lf[3:1]});
      repeat (5) @(negedge mclk_i);
      wr_p(2'h2 >> lf[0], {1'b0, lf[6:4]});
      wait_quiet();
      `CHK("vid_code", 8'h22 + {2'h0, cur, 2'h0}, vid_code_o)
    end
    wr_p(2'h3, 4'h2);
    wait_quiet();
    idle_req(0, 1'b0, 3'h1);
    repeat (6) @(negedge mclk_i);
    q_cst.push_back(3'h1);
    idle_req(0, 1'b1, 3'h3);
    wait_quiet();
    q_cst = '{3'h0, 3'h1};
    wake(0, 2'h2);
    idle_req(0, 1'b1, 3'h6);
    wait_quiet();
    q_cst = '{3'h0, 3'h3};
    idle_req(0, 1'b0, 3'h3);
    wait_quiet();
    `CHK("clk_gate", 1'b1, core_clk_gate_o[0])
    q_cst = '{3'h0, 3'h6};
    wake(0, 2'h1);
    idle_req(0, 1'b0, 3'h6);
    wait_quiet();
    `CHK("power_off", 1'b1, core_power_off_o[0])
    q_cst.push_back(3'h0);
    wake(0, 2'h1);
    wait_quiet();
    wake(0, 2'h2);
    smt_enable_i = 1'b0;
    q_cst = '{3'h1, 3'h0};
    idle_req(0, 1'b1, 3'h1);
    wake(0, 2'h2);
    wait_quiet();
    c1e_enable_i = 1'b1;
    idle_req(1, 1'b0, 3'h1);
    repeat (6) @(negedge mclk_i);
    q_cst.push_back(3'h2);
    q_ratio.push_back(4'h0);
    idle_req(0, 1'b0, 3'h1);
    wait_quiet();
    `CHK("vid_code", 8'h20, vid_code_o)
    q_cst.push_back(3'h0);
    q_ratio.push_back(4'h2);
    wake(0, 2'h1);
    wake(1, 2'h1);
    wait_quiet();
    `CHK("vid_code", 8'h2A, vid_code_o)
    q_cst.push_back(3'h1);
    idle_req(0, 1'b1, 3'h1);
    wait_quiet();
    // core 1 disabled: only halted core 0 counts, so c1e
    core_enable_i = 2'h1;
    q_cst.push_back(3'h2);
    q_ratio.push_back(4'h0);
    wait_quiet();
    `CHK("vid_code", 8'h20, vid_code_o)
    sys_rst_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    sys_rst_i = 1'b0;
    `CHK("core_cstate", 3'h0, core_cstate_o[0])
    tally_and_finish();
  end
endmodule : core_power_state_coordinator_tb_top
